// ---- fruit_pkg.sv ----
package fruit_pkg;
    localparam int WORD_W = 16;
    localparam int NUM_GEN = 6;
    // Command codes on the command bus.
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RESET = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_LOAD = 2'h3;
    // Seeding sequencer counts.
    localparam logic [3:0] SEQ_A_START = 4'h0;
    localparam logic [3:0] SEQ_A_MAX = 4'hf;
    localparam logic [3:0] SEQ_B_START = 4'h5;
    localparam logic [3:0] SEQ_B_STOP = 4'h8;
    localparam int SEED_ONES = 3;
    localparam logic [4:0] BATCH_LEN = 5'h10;
    // Generator lengths and tap masks (bit i is stage i+1).
    localparam int LEN_7 = 7;
    localparam int LEN_11 = 11;
    localparam int LEN_15 = 15;
    localparam int LEN_17 = 17;
    localparam logic [16:0] TAPS_7 = 17'h00060;
    localparam logic [16:0] TAPS_11 = 17'h00500;
    localparam logic [16:0] TAPS_15 = 17'h06000;
    localparam logic [16:0] TAPS_17 = 17'h12000;

    typedef struct packed {
        logic [1:0] code;
        logic [WORD_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic [WORD_W-1:0] rate;
        logic [WORD_W-1:0] ms_ratio;
        logic [WORD_W-1:0] fixed_ratio;
    } load_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FILL = 2'b01,
        SEQ_BATCH = 2'b11
    } seq_state_t;
endpackage

// ---- fruit_lfsr.sv ----
`timescale 1ns/1ps
`default_nettype none
module fruit_lfsr #(
    parameter int LEN = 7,
    parameter logic [16:0] TAPS = 17'h00060
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic seed_sel_in,
    input wire logic seed_bit_in,
    output logic [LEN-1:0] state_out
);
    initial begin
        if (!(LEN == 7 || LEN == 11 || LEN == 15 || LEN == 17))
            $error("fruit_lfsr length must be 7, 11, 15 or 17");
    end

    wire feedback = ^(state_out & TAPS[LEN-1:0]);
    // The first stage acts as a toggle stage: its input is combined with
    // its own output, so an extra gate in that feedback path cancels the toggle.
    wire toggle_in = feedback ^ state_out[0];
    // While seeding, the loop is broken and seed bits shift straight in.
    wire shift_in = seed_sel_in ? seed_bit_in : (toggle_in ^ state_out[0]);
    wire [LEN-1:0] next_state = {state_out[LEN-2:0], shift_in};

    always_ff @(posedge mclk_in) begin
        if (reset_in)
            state_out <= {{(LEN-1){1'b0}}, 1'b1};
        else
            state_out <= next_state;
    end

    chk_never_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
        !seed_sel_in |-> ##1 (state_out != '0 || $past(seed_sel_in)))
        else $error("generator reached all-zero state");
endmodule
`default_nettype wire

// ---- fruit_random_param_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module fruit_random_param_gen (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire fruit_pkg::cmd_t cmd_in,
    input wire fruit_pkg::load_t load_in,
    output logic [fruit_pkg::WORD_W-1:0] read_data_out,
    output logic read_valid_out,
    output logic busy_out,
    output logic [fruit_pkg::WORD_W-1:0] rate_out,
    output logic [fruit_pkg::WORD_W-1:0] ms_ratio_out,
    output logic [fruit_pkg::WORD_W-1:0] fixed_ratio_out,
    output logic [fruit_pkg::WORD_W-1:0] interval_out,
    output logic interval_valid_out
);
    localparam int W = fruit_pkg::WORD_W;
    localparam int SEED_LEN = fruit_pkg::LEN_17;

    fruit_pkg::seq_state_t state;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    logic [4:0] seed_pos;
    logic [4:0] batch_cnt;
    logic [2:0] word_idx;
    logic reading;

    wire is_reset = cmd_in.code == fruit_pkg::CMD_RESET;
    wire is_read = cmd_in.code == fruit_pkg::CMD_READ;
    wire is_load = cmd_in.code == fruit_pkg::CMD_LOAD;
    wire a_full = cnt_a == fruit_pkg::SEQ_A_MAX;
    wire b_done = cnt_b == fruit_pkg::SEQ_B_STOP;
    // Seed select is high from the reset command until counter B freezes.
    wire seed_sel = (state == fruit_pkg::SEQ_FILL) && !b_done;
    // Serial seed pattern: zeros first, then three ones in the last three
    // shifts. Every register, short or long, then holds its three ones in
    // the low stages and zeros above them, so none is left all-zero.
    wire seed_bit =
        seed_pos > 5'(SEED_LEN) - 5'(fruit_pkg::SEED_ONES);

    wire [6:0] g_range;
    wire [10:0] g_mono;
    wire [14:0] g_power;
    wire [16:0] g_code;
    wire [14:0] g_ms;
    wire [16:0] g_time;

    fruit_lfsr #(.LEN(fruit_pkg::LEN_7), .TAPS(fruit_pkg::TAPS_7)) u_g0 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_range));
    fruit_lfsr #(.LEN(fruit_pkg::LEN_11), .TAPS(fruit_pkg::TAPS_11)) u_g1 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_mono));
    fruit_lfsr #(.LEN(fruit_pkg::LEN_15), .TAPS(fruit_pkg::TAPS_15)) u_g2 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_power));
    fruit_lfsr #(.LEN(fruit_pkg::LEN_17), .TAPS(fruit_pkg::TAPS_17)) u_g3 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_code));
    fruit_lfsr #(.LEN(fruit_pkg::LEN_15), .TAPS(fruit_pkg::TAPS_15)) u_g4 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_ms));
    fruit_lfsr #(.LEN(fruit_pkg::LEN_17), .TAPS(fruit_pkg::TAPS_17)) u_g5 (
        .mclk_in(mclk_in), .reset_in(reset_in), .seed_sel_in(seed_sel),
        .seed_bit_in(seed_bit), .state_out(g_time));

    // Group assembly: one word per generator field.
    wire [W-1:0] word_sel =
        (word_idx == 3'h0) ? W'(g_range) :
        (word_idx == 3'h1) ? W'(g_mono) :
        (word_idx == 3'h2) ? W'(g_power) :
        (word_idx == 3'h3) ? g_code[W-1:0] :
        (word_idx == 3'h4) ? W'(g_ms) : g_time[W-1:0];
    wire last_word = word_idx == 3'(fruit_pkg::NUM_GEN - 1);
    wire seed_end = (state == fruit_pkg::SEQ_FILL) && b_done &&
        (seed_pos >= 5'(SEED_LEN));

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state <= fruit_pkg::SEQ_IDLE;
            cnt_a <= fruit_pkg::SEQ_A_START;
            cnt_b <= fruit_pkg::SEQ_B_START;
            seed_pos <= 5'h0;
            batch_cnt <= 5'h0;
        end else if (is_reset) begin
            state <= fruit_pkg::SEQ_FILL;
            cnt_a <= fruit_pkg::SEQ_A_START;
            cnt_b <= fruit_pkg::SEQ_B_START;
            seed_pos <= 5'h0;
            batch_cnt <= 5'h0;
        end else begin
            case (state)
                fruit_pkg::SEQ_FILL: begin
                    if (!a_full)
                        cnt_a <= cnt_a + 4'h1;
                    else if (!b_done)
                        cnt_b <= cnt_b + 4'h1;
                    if (seed_pos < 5'(SEED_LEN))
                        seed_pos <= seed_pos + 5'h1;
                    if (seed_end)
                        state <= fruit_pkg::SEQ_BATCH;
                end
                fruit_pkg::SEQ_BATCH: begin
                    batch_cnt <= batch_cnt + 5'h1;
                    if (batch_cnt == fruit_pkg::BATCH_LEN - 5'h1)
                        state <= fruit_pkg::SEQ_IDLE;
                end
                default: state <= fruit_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reading <= 1'b0;
            word_idx <= 3'h0;
            read_data_out <= '0;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= reading;
            read_data_out <= reading ? word_sel : '0;
            if (is_read && !reading && state == fruit_pkg::SEQ_IDLE) begin
                reading <= 1'b1;
                word_idx <= 3'h0;
            end else if (reading) begin
                word_idx <= last_word ? 3'h0 : word_idx + 3'h1;
                if (last_word)
                    reading <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rate_out <= '0;
            ms_ratio_out <= '0;
            fixed_ratio_out <= '0;
        end else if (is_load) begin
            rate_out <= load_in.rate;
            ms_ratio_out <= load_in.ms_ratio;
            fixed_ratio_out <= load_in.fixed_ratio;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            interval_out <= '0;
            interval_valid_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            interval_valid_out <= state == fruit_pkg::SEQ_BATCH;
            interval_out <= g_time[W-1:0];
            busy_out <= state != fruit_pkg::SEQ_IDLE || reading;
        end
    end

    chk_seed_counts: assert property (@(posedge mclk_in) disable iff (reset_in)
        is_reset |=> (cnt_a == 4'h0 && cnt_b == 4'h5))
        else $error("seeding counters not preset");
    chk_b_waits: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == fruit_pkg::SEQ_FILL && !a_full && !is_reset)
        |=> $stable(cnt_b))
        else $error("counter B moved before A overflow");
    chk_b_stops: assert property (@(posedge mclk_in) disable iff (reset_in)
        (b_done && !is_reset) |=> b_done)
        else $error("counter B passed eight");
    chk_batch_len: assert property (@(posedge mclk_in) disable iff (reset_in)
        ($rose(interval_valid_out) && !is_reset) |->
        interval_valid_out [*8])
        else $error("interval batch too short");
    chk_load_update: assert property (@(posedge mclk_in) disable iff (reset_in)
        is_load |=> rate_out == $past(load_in.rate))
        else $error("load did not update rate");
    chk_read_group: assert property (@(posedge mclk_in) disable iff (reset_in)
        $rose(read_valid_out) |-> read_valid_out [*6] ##1 !read_valid_out)
        else $error("read group not six words");
endmodule
`default_nettype wire

// ---- fruit_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fruit_ctrl_model (
    input wire logic mclk_in,
    output var fruit_pkg::cmd_t cmd_out,
    output var fruit_pkg::load_t load_out
);
    initial begin
        cmd_out = '0;
        load_out = '0;
    end
    // A command is held across exactly one rising edge.
    task automatic issue(input logic [1:0] code, input fruit_pkg::load_t p);
        @(negedge mclk_in);
        cmd_out.code = code;
        load_out = p;
        @(negedge mclk_in);
        cmd_out.code = fruit_pkg::CMD_NONE;
        // A released load bus shows the inverse of its last value.
        load_out = ~p;
    endtask
endmodule
`default_nettype wire

// ---- tb_fruit_random_param_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_fruit_random_param_gen;
    logic mclk_in;
    logic reset_in;
    fruit_pkg::cmd_t cmd;
    fruit_pkg::load_t ld;
    fruit_pkg::load_t ld0;
    logic [15:0] rd, rate, msr, fxr, iv;
    logic rv, busy, ivv;
    int fails;
    int samples_checked;
    logic [15:0] ga [6], gb [6], gc [6], ia [16], ib [16];
    fruit_ctrl_model u_fruit_ctrl_model (.mclk_in(mclk_in), .cmd_out(cmd),
        .load_out(ld));
    fruit_random_param_gen u_fruit_random_param_gen (.mclk_in(mclk_in),
        .reset_in(reset_in), .cmd_in(cmd), .load_in(ld),
        .read_data_out(rd), .read_valid_out(rv), .busy_out(busy),
        .rate_out(rate), .ms_ratio_out(msr), .fixed_ratio_out(fxr),
        .interval_out(iv), .interval_valid_out(ivv));
    task automatic check_word(string w, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic check_bit(string w, logic e, logic g);
        check_word(w, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic check_count(string w, int e, int g);
        check_word(w, e[15:0], g[15:0]);
    endtask
    task automatic stop_test();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic load_one(input fruit_pkg::load_t p);
        u_fruit_ctrl_model.issue(fruit_pkg::CMD_LOAD, p);
        // Look again once the load bus has moved away.
        @(negedge mclk_in);
        check_word("rate", p.rate, rate);
        check_word("ms ratio", p.ms_ratio, msr);
        check_word("fixed ratio", p.fixed_ratio, fxr);
    endtask
    task automatic run_reset(output logic [15:0] v [16]);
        int k;
        int n;
        k = 0;
        n = 0;
        u_fruit_ctrl_model.issue(fruit_pkg::CMD_RESET, ld0);
        // Busy is registered from the state, so it shows one edge later.
        @(negedge mclk_in);
        check_bit("busy after reset", 1'b1, busy);
        while (busy !== 1'b0 && k < 400) begin
            @(negedge mclk_in);
            k++;
            if (ivv === 1'b1) begin
                if (n < 16) v[n] = iv;
                n++;
            end
        end
        check_count("interval count", 16, n);
    endtask
    task automatic run_read(output logic [15:0] g [6]);
        int k;
        k = 0;
        u_fruit_ctrl_model.issue(fruit_pkg::CMD_READ, ld0);
        while (rv !== 1'b1 && k < 10) begin
            @(negedge mclk_in);
            k++;
        end
        for (int i = 0; i < 6; i++) begin
            g[i] = rd;
            check_bit("read valid", 1'b1, rv);
            @(negedge mclk_in);
        end
        check_bit("read end", 1'b0, rv);
        check_bit("range word", 1'b1, g[0] < 16'h0080 && g[0] != 16'h0000);
        check_bit("mono word", 1'b1, g[1] < 16'h0800);
        check_bit("power word", 1'b1, g[2] < 16'h8000);
        check_bit("ms word", 1'b1, g[4] < 16'h8000);
    endtask
    task automatic test_seeding();
        run_reset(ia);
        run_read(ga);
        run_read(gc);
        check_bit("reads step", 1'b1, ga[0] !== gc[0] || ga[5] !== gc[5]);
        run_reset(ib);
        run_read(gb);
        for (int i = 0; i < 16; i++)
            check_word("interval repeat", ia[i], ib[i]);
        for (int i = 0; i < 6; i++)
            check_word("group repeat", ga[i], gb[i]);
    endtask
    task automatic test_read_busy();
        int seen;
        int k;
        seen = 0;
        k = 0;
        u_fruit_ctrl_model.issue(fruit_pkg::CMD_RESET, ld0);
        u_fruit_ctrl_model.issue(fruit_pkg::CMD_READ, ld0);
        while ((busy !== 1'b0 || k < 12) && k < 400) begin
            @(negedge mclk_in);
            k++;
            if (rv !== 1'b0) seen++;
        end
        check_count("read while busy", 0, seen);
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    initial begin
        #40000;
        fails++;
        stop_test();
    end
    initial begin
        fails = 0;
        samples_checked = 0;
        ld0 = '0;
        reset_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        reset_in = 1'b0;
        load_one({16'h1234, 16'h00ff, 16'hffff});
        load_one({16'hffff, 16'h0000, 16'h8001});
        test_seeding();
        test_read_busy();
        stop_test();
    end
endmodule
`default_nettype wire
